/* File: design/sbc_map.vh */
// Purpose: Constants for the serial baud clock generator.
// Assumes: Included only by the top-level design file of the block, by its bare name.
// Notes:   Definitions only; no logic.
//
// Behaviour
// RULE_01 - Reference clock: bus clock or crystal
// RULE_02 - Protocol clock: reference or half reference
// RULE_03 - Divided clock equals protocol over ratio+1
// RULE_04 - Sample source chosen by two-bit field
// RULE_05 - Predivided clock equals sample over predivider+1
// RULE_06 - Counter clock equals predivided over denominator+1
// RULE_07 - UART software keeps denominator at most 0xF
// RULE_08 - Time counter runs only when enabled
// RULE_09 - Time counter source: protocol or divided
// RULE_10 - Auto-baud rewrites ratio at fourth falling edge
// RULE_11 - Register resets to 0x0000_3C00
// RULE_12 - Reserved bits read zero, ignore writes
`ifndef SBC_MAP_VH
`define SBC_MAP_VH

// Register map
`define SBC_ADDR_W          8
`define SBC_OFF_CLOCK_GEN   8'h08
`define SBC_RESET_CLOCK_GEN 32'h0000_3c00
`define SBC_WRITE_MASK      32'h03ff_7f3f

// Field positions of baud_clock_gen
`define SBC_REF_SEL_BIT     0
`define SBC_PROT_SEL_BIT    1
`define SBC_SAMP_SEL_HI     3
`define SBC_SAMP_SEL_LO     2
`define SBC_TM_EN_BIT       4
`define SBC_TM_SRC_BIT      5
`define SBC_PREDIV_HI       9
`define SBC_PREDIV_LO       8
`define SBC_DENOM_HI        14
`define SBC_DENOM_LO        10
`define SBC_RATIO_HI        25
`define SBC_RATIO_LO        16

// Field widths
`define SBC_RATIO_W         10
`define SBC_PREDIV_W        2
`define SBC_DENOM_W         5
`define SBC_TM_W            10
`define SBC_BAUD_W          11

// Sample source encodings
`define SBC_SAMP_DIV        2'h0
`define SBC_SAMP_PROT       2'h1
`define SBC_SAMP_SERIAL     2'h2
`define SBC_SAMP_REF        2'h3

// Auto-baud: falling edges of the 0x55 frame counted before the update
`define SBC_EDGE_MEASURE    3'h3
`define SBC_EDGE_UPDATE     3'h4

`endif

/* File: design/sbc_pin_sync.v */
// Purpose: Two-stage synchroniser with edge pulses, one lane per pin.
// Assumes: Pins are asynchronous to ref_clk and far slower than it.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
module sbc_pin_sync #(
  parameter N = 1
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         rst,
  // Pins
  input  wire [N-1:0] pin_in,
  // Synchronised level and edge pulses
  output wire [N-1:0] level,
  output wire [N-1:0] rise,
  output wire [N-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_lane
      reg meta_r;
      reg sync_r;
      reg last_r;
      always @(posedge ref_clk) begin
        if (rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          last_r <= 1'b0;
        end else begin
          meta_r <= pin_in[i];
          sync_r <= meta_r;
          last_r <= sync_r;
        end
      end
      assign level[i] = sync_r;
      assign rise[i]  = sync_r & ~last_r;
      assign fall[i]  = ~sync_r & last_r;
    end
  endgenerate

endmodule

/* File: design/sbc_divider.v */
// Purpose: Enable-pulse divider: one output pulse per ratio+1 input pulses.
// Assumes: tick_in is a one-cycle enable on ref_clk.
// Notes:   A ratio of zero passes every input pulse straight through.
`timescale 1ns/10ps
module sbc_divider #(
  parameter W = 10
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         rst,
  // Input rate and ratio
  input  wire         tick_in,
  input  wire [W-1:0] ratio,
  // Divided rate, combinational from the counter
  output wire         tick_out
);

  reg [W-1:0] cnt_r;
  wire        wrap;

  // Comparing with >= lets a ratio lowered mid-count wrap at once
  assign wrap     = (cnt_r >= ratio);
  assign tick_out = tick_in & wrap;

  always @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= {W{1'b0}};
    end else if (tick_in) begin
      if (wrap) begin
        cnt_r <= {W{1'b0}};
      end else begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* File: design/sbc_top.v */
// Purpose: Baud clock generator: source selection and division of the
//          reference, protocol, divided and sample rates, time measure
//          counter and UART auto-baud update of the divider ratio.
// Assumes: Every derived clock is a one-cycle enable on ref_clk (200 MHz).
//          Crystal and serial clock pins are below 100 MHz.
// Notes:   Register port: read data valid only in the cycle after rd_en.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`include "sbc_map.vh"
module sbc_top (
  // Clock and reset
  input  wire                   ref_clk,
  input  wire                   rst,
  // Register port
  input  wire [`SBC_ADDR_W-1:0] addr,
  input  wire [31:0]            wr_data,
  input  wire                   wr_en,
  input  wire                   rd_en,
  output reg  [31:0]            rd_data,
  // Clock sources
  input  wire                   pclk_tick,
  input  wire                   external_crystal,
  input  wire                   serial_clk_pin,
  // UART auto-baud context
  input  wire                   uart_mode,
  input  wire                   auto_baud_enable,
  input  wire                   rx_pin,
  // Derived rates
  output reg                    reference_tick,
  output reg                    protocol_tick,
  output reg                    divided_tick,
  output reg                    sample_tick,
  output reg                    predivided_tick,
  output reg                    sample_counter_tick,
  // Time measurement and auto-baud status
  output reg  [`SBC_TM_W-1:0]   tm_count,
  output reg                    tm_running,
  output reg                    baud_updated,
  output reg  [`SBC_BAUD_W-1:0] baud_detect_interval
);

  ////////////////////////////////////////////////////////////////////////////
  // Register and fields

  reg  [31:0]                baud_clock_gen_r;
  reg  [31:0]                baud_clock_gen_nxt;

  wire                       reference_source_select;
  wire                       protocol_source_select;
  wire [1:0]                 sample_source_select;
  wire                       time_measure_enable;
  wire                       timer_source_select;
  wire [`SBC_PREDIV_W-1:0]   sample_predivider;
  wire [`SBC_DENOM_W-1:0]    sample_denominator;
  wire [`SBC_RATIO_W-1:0]    divider_ratio;

  assign reference_source_select = baud_clock_gen_r[`SBC_REF_SEL_BIT];
  assign protocol_source_select  = baud_clock_gen_r[`SBC_PROT_SEL_BIT];
  assign sample_source_select    = baud_clock_gen_r[`SBC_SAMP_SEL_HI:`SBC_SAMP_SEL_LO];
  assign time_measure_enable     = baud_clock_gen_r[`SBC_TM_EN_BIT];
  assign timer_source_select     = baud_clock_gen_r[`SBC_TM_SRC_BIT];
  assign sample_predivider       = baud_clock_gen_r[`SBC_PREDIV_HI:`SBC_PREDIV_LO];
  assign sample_denominator      = baud_clock_gen_r[`SBC_DENOM_HI:`SBC_DENOM_LO];
  assign divider_ratio           = baud_clock_gen_r[`SBC_RATIO_HI:`SBC_RATIO_LO];

  wire                       reg_hit;
  assign reg_hit = (addr == `SBC_OFF_CLOCK_GEN);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: crystal, serial clock, receive line

  wire [2:0]                 pin_level;
  wire [2:0]                 pin_rise;
  wire [2:0]                 pin_fall;

  sbc_pin_sync #(
    .N (3)
  ) u_pins (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  ({rx_pin, serial_clk_pin, external_crystal}),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  wire                       xtal_tick;
  wire                       sclk_tick;
  wire                       rx_fall;
  assign xtal_tick = pin_rise[0];
  assign sclk_tick = pin_rise[1];
  assign rx_fall   = pin_fall[2];

  ////////////////////////////////////////////////////////////////////////////
  // Reference and protocol rates

  wire                       ref_tick;
  reg                        half_phase_r;
  wire                       half_ref_tick;
  wire                       prot_tick;

  assign ref_tick = reference_source_select ? xtal_tick : pclk_tick;  // [RULE_01]

  // Half reference: every second reference pulse
  always @(posedge ref_clk) begin
    if (rst) begin
      half_phase_r <= 1'b0;
    end else if (ref_tick) begin
      half_phase_r <= ~half_phase_r;
    end
  end
  assign half_ref_tick = ref_tick & half_phase_r;

  assign prot_tick = protocol_source_select ? half_ref_tick : ref_tick;  // [RULE_02]

  ////////////////////////////////////////////////////////////////////////////
  // Divided clock

  wire                       div_tick;

  sbc_divider #(
    .W (`SBC_RATIO_W)
  ) u_div_clk (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (prot_tick),
    .ratio    (divider_ratio),
    .tick_out (div_tick)  // [RULE_03]
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock and its two division stages

  reg                        samp_tick;
  wire                       pds_tick;
  wire                       ds_tick;

  always @* begin
    case (sample_source_select)  // [RULE_04]
      `SBC_SAMP_DIV:    samp_tick = div_tick;
      `SBC_SAMP_PROT:   samp_tick = prot_tick;
      `SBC_SAMP_SERIAL: samp_tick = sclk_tick;
      `SBC_SAMP_REF:    samp_tick = ref_tick;
      default:          samp_tick = div_tick;
    endcase
  end

  sbc_divider #(
    .W (`SBC_PREDIV_W)
  ) u_predivider (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (samp_tick),
    .ratio    (sample_predivider),
    .tick_out (pds_tick)  // [RULE_05]
  );

  // No clamp in UART mode: keeping the denominator legal is up to software
  sbc_divider #(
    .W (`SBC_DENOM_W)
  ) u_denominator (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (pds_tick),
    .ratio    (sample_denominator),
    .tick_out (ds_tick)  // [RULE_06]
  );

  ////////////////////////////////////////////////////////////////////////////
  // Time measurement counter

  wire                       tm_tick;
  assign tm_tick = timer_source_select ? div_tick : prot_tick;  // [RULE_09]

  // Cleared while disabled so every measurement starts from zero
  always @(posedge ref_clk) begin
    if (rst) begin
      tm_count   <= {`SBC_TM_W{1'b0}};
      tm_running <= 1'b0;
    end else begin
      tm_running <= time_measure_enable;
      if (!time_measure_enable) begin
        tm_count <= {`SBC_TM_W{1'b0}};  // [RULE_08]
      end else if (tm_tick) begin
        tm_count <= tm_count + {{(`SBC_TM_W-1){1'b0}}, 1'b1};  // [RULE_08]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto-baud detection on a received 0x55
  // A 0x55 frame falls at start, bit 1, bit 3, bit 5 and bit 7. The span from the
  // third to the fourth fall covers bits 3 and 4, two bit times; half of it
  // is the bit time, in protocol clock periods.

  localparam AB_IDLE = 2'h0;
  localparam AB_WAIT = 2'h1;
  localparam AB_DONE = 2'h2;

  reg  [1:0]                 ab_state_r;
  reg  [1:0]                 ab_state_nxt;
  reg  [2:0]                 ab_edges_r;
  reg  [`SBC_BAUD_W-1:0]     ab_span_r;
  wire                       ab_armed;
  wire                       ab_fire;
  wire [`SBC_RATIO_W-1:0]    ab_ratio;
  wire                       ab_span_full;

  assign ab_armed     = uart_mode & auto_baud_enable;
  assign ab_fire      = (ab_state_r == AB_WAIT) & rx_fall &
                        (ab_edges_r == `SBC_EDGE_MEASURE);
  assign ab_span_full = &ab_span_r;
  // Bit time minus one; a span under two periods gives a ratio of zero
  assign ab_ratio     = (ab_span_r[`SBC_BAUD_W-1:1] == {`SBC_RATIO_W{1'b0}}) ?
                        {`SBC_RATIO_W{1'b0}} :
                        (ab_span_r[`SBC_BAUD_W-1:1] - {{(`SBC_RATIO_W-1){1'b0}}, 1'b1});

  always @* begin
    case (ab_state_r)
      AB_IDLE: ab_state_nxt = ab_armed ? AB_WAIT : AB_IDLE;
      AB_WAIT: ab_state_nxt = !ab_armed ? AB_IDLE : (ab_fire ? AB_DONE : AB_WAIT);
      AB_DONE: ab_state_nxt = ab_armed ? AB_DONE : AB_IDLE;
      default: ab_state_nxt = AB_IDLE;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ab_state_r <= AB_IDLE;
      ab_edges_r <= 3'h0;
      ab_span_r  <= {`SBC_BAUD_W{1'b0}};
    end else begin
      ab_state_r <= ab_state_nxt;
      if (ab_state_r != AB_WAIT) begin
        ab_edges_r <= 3'h0;
        ab_span_r  <= {`SBC_BAUD_W{1'b0}};
      end else if (rx_fall) begin
        ab_edges_r <= ab_edges_r + 3'h1;
        // The fall cycle's own tick opens the span, so it counts whole periods
        ab_span_r  <= {{(`SBC_BAUD_W-1){1'b0}}, prot_tick};
      end else if (prot_tick && !ab_span_full &&
                   ab_edges_r == `SBC_EDGE_MEASURE) begin
        // Saturates so a stalled line cannot wrap into a short bit time
        ab_span_r  <= ab_span_r + {{(`SBC_BAUD_W-1){1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write, including the hardware ratio update

  always @* begin
    baud_clock_gen_nxt = baud_clock_gen_r;
    if (wr_en && reg_hit) begin
      baud_clock_gen_nxt = wr_data & `SBC_WRITE_MASK;  // [RULE_12]
    end
    // Hardware update wins over a software write in the same cycle
    if (ab_fire) begin
      baud_clock_gen_nxt[`SBC_RATIO_HI:`SBC_RATIO_LO] = ab_ratio;  // [RULE_10]
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      baud_clock_gen_r <= `SBC_RESET_CLOCK_GEN;  // [RULE_11]
    end else begin
      baud_clock_gen_r <= baud_clock_gen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port and registered outputs

  always @(posedge ref_clk) begin
    if (rst) begin
      rd_data              <= 32'h0000_0000;
      reference_tick       <= 1'b0;
      protocol_tick        <= 1'b0;
      divided_tick         <= 1'b0;
      sample_tick          <= 1'b0;
      predivided_tick      <= 1'b0;
      sample_counter_tick  <= 1'b0;
      baud_updated         <= 1'b0;
      baud_detect_interval <= {`SBC_BAUD_W{1'b0}};
    end else begin
      // Unmapped addresses and idle cycles read zero
      if (rd_en && reg_hit) begin
        rd_data <= baud_clock_gen_r & `SBC_WRITE_MASK;  // [RULE_12]
      end else begin
        rd_data <= 32'h0000_0000;
      end
      reference_tick      <= ref_tick;
      protocol_tick       <= prot_tick;
      divided_tick        <= div_tick;
      sample_tick         <= samp_tick;
      predivided_tick     <= pds_tick;
      sample_counter_tick <= ds_tick;
      baud_updated        <= ab_fire;
      if (ab_fire) begin
        baud_detect_interval <= ab_span_r;
      end
    end
  end

endmodule

/* File: sim/sbc_top_monitor.sv */
// Purpose: Port-level checks on the baud clock generator.
// Assumes: Bits 15:0 of the register change only through the register port.
// Notes:   Bits 15:0 are shadowed. The ratio field is left out because
//          the auto-baud logic can rewrite it without a software write.
`timescale 1ns/10ps
module sbc_top_monitor (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Register port
  input wire [7:0]  addr,
  input wire [31:0] wr_data,
  input wire        wr_en,
  input wire        rd_en,
  input wire [31:0] rd_data,
  // Clock sources and auto-baud context
  input wire        pclk_tick,
  input wire        external_crystal,
  input wire        serial_clk_pin,
  input wire        uart_mode,
  input wire        auto_baud_enable,
  input wire        rx_pin,
  // Derived rates and status
  input wire        reference_tick,
  input wire        protocol_tick,
  input wire        divided_tick,
  input wire        sample_tick,
  input wire        predivided_tick,
  input wire        sample_counter_tick,
  input wire [9:0]  tm_count,
  input wire        tm_running,
  input wire        baud_updated,
  input wire [10:0] baud_detect_interval
);
  reg [15:0] cfg_r;
  reg [15:0] cfg_q_r;
  reg        rd_q_r;

  always @(posedge ref_clk) begin
    if (rst)
      cfg_r <= 16'h3c00;
    else if (wr_en && addr == 8'h08)
      cfg_r <= wr_data[15:0] & 16'h7f3f;
    cfg_q_r <= cfg_r;
    rd_q_r <= rd_en && addr == 8'h08;
  end

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_ref_bus_clock: assert property (!cfg_r[0] |=> reference_tick == $past(pclk_tick))
    else $error("reference tick does not follow the bus clock");
  chk_prot_full_rate: assert property (!cfg_q_r[1] |-> protocol_tick == reference_tick)
    else $error("protocol tick differs from reference tick");
  chk_div_subset: assert property (divided_tick |-> protocol_tick)
    else $error("divided tick without protocol tick");
  chk_sample_source: assert property (cfg_q_r[3:2] != 2'h2 |-> sample_tick ==
    (cfg_q_r[3] ? reference_tick : cfg_q_r[2] ? protocol_tick : divided_tick))
    else $error("sample tick from wrong source");
  chk_prediv_bypass: assert property (cfg_q_r[9:8] == 2'h0 |-> predivided_tick == sample_tick)
    else $error("predivider zero does not pass sample tick");
  chk_counter_subset: assert property (sample_counter_tick |-> predivided_tick)
    else $error("counter tick without predivided tick");
  chk_tm_running: assert property (tm_running == cfg_q_r[4])
    else $error("running flag differs from enable bit");
  chk_tm_cleared: assert property (!cfg_q_r[4] |-> tm_count == 10'h0)
    else $error("time count not cleared while disabled");
  chk_tm_step: assert property ($changed(tm_count) && cfg_q_r[4] |-> tm_count == $past(tm_count) + 10'h1)
    else $error("time count moved by other than one");
  chk_read_value: assert property (rd_q_r |-> rd_data == {6'h0, rd_data[25:16], cfg_q_r})
    else $error("read data wrong or reserved bits set");
  chk_read_idle: assert property (!rd_q_r |-> rd_data == 32'h0)
    else $error("read data not zero outside a read");
  chk_baud_pulse: assert property (baud_updated |=> !baud_updated)
    else $error("ratio update flag longer than one cycle");

  cover property (baud_updated);
  cover property (sample_counter_tick && cfg_q_r[3:2] == 2'h2);
  cover property (rd_q_r && rd_data != 32'h0);
endmodule

/* File: sim/sbc_top_tb.sv */
// Purpose: Self-checking bench for the baud clock generator.
// Assumes: Bus clock enable held high once reset is released.
// Notes:   Rates are counted over 360 cycles, a whole number of every
//          expected period, so divider phase drops out of the counts.
`timescale 1ns/10ps
module sbc_top_tb;
  reg          ref_clk, rst, wr_en, rd_en, pclk_tick;
  reg          external_crystal, serial_clk_pin;
  reg          uart_mode, auto_baud_enable, rx_pin;
  reg  [7:0]   addr;
  reg  [31:0]  wr_data;
  wire [31:0]  rd_data;
  wire         reference_tick, protocol_tick, divided_tick;
  wire         sample_tick, predivided_tick, sample_counter_tick;
  wire         tm_running, baud_updated;
  wire [9:0]   tm_count;
  wire [10:0]  baud_detect_interval;
  int          miscompares, n_checks, n_upd;
  int          cnt[6];
  logic [31:0] cfgs[4] = '{32'h0002_0930, 32'h0000_0007, 32'h0000_0e08, 32'h0004_201e};
  int          exps[4][7] = '{'{360, 360, 120, 120, 60, 20, 120},
                              '{90, 45, 45, 45, 45, 45, 0},
                              '{360, 360, 360, 60, 20, 5, 0},
                              '{360, 180, 36, 360, 360, 40, 180}};

  sbc_top DUT (.*);

  //////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Crystal and serial pins run free, off the clock edges
  initial begin
    external_crystal = 1'h0;
    #1.3;
    forever #10 external_crystal = ~external_crystal;
  end
  initial begin
    serial_clk_pin = 1'h0;
    #0.7;
    forever #15 serial_clk_pin = ~serial_clk_pin;
  end
  always @(posedge ref_clk) if (baud_updated === 1'h1) n_upd++;

  //////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    @(posedge ref_clk);
    wr_en <= 1'h0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge ref_clk);
    rd_en <= 1'h0;
    @(posedge ref_clk);
    check("rd_data", rd_data, e);
  endtask
  task measure(input int i);
    logic [9:0] t0;
    logic [5:0] tk;
    wr(8'h08, cfgs[i]);
    repeat (80) @(posedge ref_clk);
    t0 = tm_count;
    cnt = '{default:0};
    repeat (360) begin
      @(posedge ref_clk);
      tk = {sample_counter_tick, predivided_tick, sample_tick,
               divided_tick, protocol_tick, reference_tick};
      for (int k = 0; k < 6; k++) cnt[k] += tk[k];
    end
    for (int k = 0; k < 6; k++) check("tick count", cnt[k], exps[i][k]);
    t0 = tm_count - t0;
    check("tm_count step", t0, exps[i][6]);
  endtask
  task frame(input int t);
    logic [9:0] bits;
    bits = {1'h1, 8'h55, 1'h0};
    for (int b = 0; b < 10; b++) begin
      rx_pin <= bits[b];
      repeat (t) @(posedge ref_clk);
    end
    repeat (20) @(posedge ref_clk);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    stop_test;
  end
  initial begin
    rst = 1'h1;
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr = 8'h0;
    wr_data = 32'h0;
    pclk_tick = 1'h0;
    uart_mode = 1'h0;
    auto_baud_enable = 1'h0;
    rx_pin = 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    pclk_tick <= 1'h1;
    rd(8'h08, 32'h0000_3c00);
    rd(8'h0c, 32'h0);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h03ff_7f3f);
    wr(8'h0c, 32'h0);
    rd(8'h08, 32'h03ff_7f3f);
    $display("test register access done");
    for (int i = 0; i < 4; i++) measure(i);
    $display("test clock rates done");
    wr(8'h08, 32'h0000_3c00);
    auto_baud_enable <= 1'h1;
    frame(8);
    check("update count", n_upd, 0);
    uart_mode <= 1'h1;
    repeat (4) @(posedge ref_clk);
    frame(8);
    check("update count", n_upd, 1);
    check("baud_detect_interval", baud_detect_interval, 16);
    rd(8'h08, 32'h0007_3c00);
    frame(4);
    rd(8'h08, 32'h0007_3c00);
    $display("test auto baud done");
    stop_test;
  end
endmodule

bind sbc_top sbc_top_monitor u_mon (.*);
